// file: valve_io_pkg.sv
// Purpose: Shared constants for the valve terminal I/O block
// Assumes: 100 MHz system clock, 32-bit AXI4-Lite register bus
// Notes:   Byte offsets, field positions and error codes live here
package valve_io_pkg;
  // ----------------------------------------------------------------
  // Sizes and clock
  // ----------------------------------------------------------------
  localparam int VALVES  = 24;
  localparam int INPUTS  = 32;
  localparam int CLK_KHZ = 100000;

  // ----------------------------------------------------------------
  // Times in their own units
  // ----------------------------------------------------------------
  localparam int FILT_MS  = 2;   // Least stable time of an input
  localparam int WDOG_MS  = 100; // Signal monitoring time
  localparam int TICK_MS  = 250; // Flash pulse and gap width
  localparam int NEGO_S   = 60;  // Address negotiation limit
  localparam int PAUSE_TK = 6;   // Pause-state ticks; codes sit 8 dark ticks apart

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FACT = 8'h04;
  localparam logic [7:0] ADDR_FVAL = 8'h08;
  localparam logic [7:0] ADDR_VOUT = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_IMG  = 8'h14;
  localparam logic [7:0] ADDR_NETW = 8'h18;
  localparam logic [7:0] ADDR_NETA = 8'h1C;

  // Control fields and input packing modes
  localparam int CTRL_FILT = 0;
  localparam int CTRL_MODE = 1;
  localparam logic [1:0] MODE_NORM  = 2'h0;
  localparam logic [1:0] MODE_SHIFT = 2'h1;
  localparam logic [1:0] MODE_HALF  = 2'h2;
  localparam logic [31:0] CTRL_RST  = 32'h00000001;

  // Status fields
  localparam int ST_BF   = 0;
  localparam int ST_BO   = 1;
  localparam int ST_ERR  = 2; // Four latched error bits from here
  localparam int ST_FALL = 6;

  // Error type and number codes
  localparam logic [2:0] TYPE_MAIN = 3'h3;
  localparam logic [2:0] TYPE_PER  = 3'h4;
  localparam logic [2:0] NUM_SUP   = 3'h1;
  localparam logic [2:0] NUM_EEP   = 3'h3;
  localparam logic [2:0] NUM_LOST  = 3'h2;

  localparam logic [31:0] DEF_ADDR = 32'hC0A80064;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage

// file: valve_io_fault_and_input_mapping.sv
// Purpose: Valve fault reaction, input filter and packing, lamps
// Assumes: Status inputs other than din_i come from same-clock logic
// Notes:   Network settings are adopted only when leaving reset
//
// How it works
// - Selector lit: flash count equals error type
// - Selector dark: flash count equals error number
// - Main output supply loss is type 3/1
// - Peripheral supply loss is type 4/1
// - Peripheral terminal lost is type 4/2
// - Bus lamp green with configuration and master
// - Errors latch until power-on reset
// - Mode register picks packing; normal ascends
// - Shifted mode alternates inputs over byte pairs
// - Halved mode packs odd inputs only
// - Filter accepts levels stable at least 2 ms
// - Two per-valve byte settings define fault state
// - Action 0 drives the fault value
// - Action 1 holds state at fault onset
// - Fault value 0 off, 1 actuated
// - Lowest valve of each group is LSB
// - Negotiation timeout falls back to default address
// - Network settings apply after next power cycle
// - Monitoring timeout declares bus fault, lamps swap
// - Selector lamp chooses type or number display
`timescale 1ns/1ps
`default_nettype none
module valve_io_fault_and_input_mapping #(
  parameter logic [17:0] FILT_CYC = 18'(valve_io_pkg::FILT_MS
                                     * valve_io_pkg::CLK_KHZ),
  parameter logic [31:0] WDOG_CYC = 32'(valve_io_pkg::WDOG_MS
                                     * valve_io_pkg::CLK_KHZ),
  parameter logic [31:0] TICK_CYC = 32'(valve_io_pkg::TICK_MS
                                     * valve_io_pkg::CLK_KHZ),
  parameter logic [39:0] NEGO_CYC = 40'(64'(valve_io_pkg::NEGO_S)
                                     * 64'd1000
                                     * 64'(valve_io_pkg::CLK_KHZ))
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic [31:0] din_i,
  input  wire logic        frame_i,
  input  wire logic        config_ok_i,
  input  wire logic        master_conn_i,
  input  wire logic        main_supply_ok_i,
  input  wire logic        eeprom_fail_i,
  input  wire logic        per_supply_ok_i,
  input  wire logic        per_lost_i,
  input  wire logic        nv_nego_i,
  input  wire logic [31:0] nv_addr_i,
  input  wire logic        addr_given_i,
  input  wire logic [31:0] addr_value_i,
  output logic [23:0]      valve_o,
  output logic [31:0]      process_image_o,
  output logic [31:0]      net_addr_o,
  output logic [31:0]      net_addr_store_o,
  output logic             bus_ok_lamp_o,
  output logic             bus_fault_lamp_o,
  output logic             failure_selector_lamp_o,
  output logic             failure_count_lamp_o
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Byte-enable merge, shared by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Input packing into the process image
  function automatic logic [31:0] pack(input logic [31:0] x,
                                       input logic [1:0]  m);
    logic [31:0] r;
    r = x; // normal: input 1 in bit 0 upward
    if (m == valve_io_pkg::MODE_SHIFT) begin
      for (int k = 0; k < 8; k++) begin
        r[k]      = x[2*k];
        r[8 + k]  = x[2*k + 1];
        r[16 + k] = x[16 + 2*k];
        r[24 + k] = x[17 + 2*k];
      end
    end else if (m == valve_io_pkg::MODE_HALF) begin
      r = '0;
      for (int k = 0; k < 16; k++) begin
        r[k] = x[2*k];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, fact_q, fval_q, vout_q, netw_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] status_w, img_q, addr_q;

  wire         wr_go  = aw_got_q & w_got_q & ~bvalid_q;
  wire [7:0]   wa     = awaddr_q[7:0];
  wire [7:0]   ra     = s_axi_araddr_i[7:0];
  wire         wa_hi  = |awaddr_q[31:8];
  wire         ra_hi  = |s_axi_araddr_i[31:8];
  wire         rd_go  = s_axi_arvalid_i & ~rvalid_q;
  wire         wr_ctl = wr_go & ~wa_hi & (wa == valve_io_pkg::ADDR_CTRL);
  wire         wr_fa  = wr_go & ~wa_hi & (wa == valve_io_pkg::ADDR_FACT);
  wire         wr_fv  = wr_go & ~wa_hi & (wa == valve_io_pkg::ADDR_FVAL);
  wire         wr_vo  = wr_go & ~wa_hi & (wa == valve_io_pkg::ADDR_VOUT);
  wire         wr_nw  = wr_go & ~wa_hi & (wa == valve_io_pkg::ADDR_NETW);
  wire         wr_ok  = wr_ctl | wr_fa | wr_fv | wr_vo | wr_nw;

  // Read selection; unmapped offsets return zero with SLVERR, set upper address bits give SLVERR with the register data
  logic [31:0] rd_w;
  logic        rd_ok;
  always_comb begin
    rd_ok = ~ra_hi;
    case (ra)
      valve_io_pkg::ADDR_CTRL: rd_w = ctrl_q;
      valve_io_pkg::ADDR_FACT: rd_w = fact_q;
      valve_io_pkg::ADDR_FVAL: rd_w = fval_q;
      valve_io_pkg::ADDR_VOUT: rd_w = vout_q;
      valve_io_pkg::ADDR_STAT: rd_w = status_w;
      valve_io_pkg::ADDR_IMG:  rd_w = img_q;
      valve_io_pkg::ADDR_NETW: rd_w = netw_q;
      valve_io_pkg::ADDR_NETA: rd_w = addr_q;
      default: begin
        rd_w  = '0;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_awready_o = ~aw_got_q;
  assign s_axi_wready_o  = ~w_got_q;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rresp_o   = rresp_q;
  assign s_axi_rdata_o   = rdata_q;

  // Address and data are latched separately, so either may come first
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (s_axi_awvalid_i & ~aw_got_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid_i & ~w_got_q) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_got_q <= 1'b0;
      end
    end
  end

  // Write response and read answer
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= valve_io_pkg::RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q  <= valve_io_pkg::RESP_OK;
      rdata_q  <= '0;
    end else begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? valve_io_pkg::RESP_OK
                          : valve_io_pkg::RESP_ERR;
      end else if (s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_w;
        rresp_q  <= rd_ok ? valve_io_pkg::RESP_OK
                          : valve_io_pkg::RESP_ERR;
      end else if (s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Software registers; fault settings keep 8 valves per byte
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_q <= valve_io_pkg::CTRL_RST;
      fact_q <= '0;
      fval_q <= '0;
      vout_q <= '0;
      netw_q <= '0;
    end else begin
      if (wr_ctl) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h7;
      if (wr_fa)  fact_q <= merge(fact_q, wdata_q, wstrb_q) & 32'hFFFFFF;
      if (wr_fv)  fval_q <= merge(fval_q, wdata_q, wstrb_q) & 32'hFFFFFF;
      if (wr_vo)  vout_q <= merge(vout_q, wdata_q, wstrb_q) & 32'hFFFFFF;
      if (wr_nw)  netw_q <= merge(netw_q, wdata_q, wstrb_q);
    end
  end

  // ----------------------------------------------------------------
  // Input synchroniser and filter
  // ----------------------------------------------------------------
  logic [31:0] s1_q, s2_q, s3_q, lvl_q, acc_q;
  logic [17:0] fcnt_q [32];
  wire         filt_en = ctrl_q[valve_io_pkg::CTRL_FILT];
  wire  [1:0]  mode    = ctrl_q[valve_io_pkg::CTRL_MODE +: 2];

  // A level counts only once the second and third stages agree
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= din_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  // One counter per input; any agreement restarts it, so glitches die
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      acc_q <= '0;
      for (int i = 0; i < 32; i++) fcnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (!filt_en) begin
          acc_q[i]  <= lvl_q[i];
          fcnt_q[i] <= '0;
        end else if (lvl_q[i] == acc_q[i]) begin
          fcnt_q[i] <= '0;
        end else if (fcnt_q[i] == FILT_CYC - 18'd1) begin
          acc_q[i]  <= lvl_q[i];
          fcnt_q[i] <= '0;
        end else begin
          fcnt_q[i] <= fcnt_q[i] + 18'd1;
        end
      end
    end
  end

  // Process image refreshed every cycle from the accepted levels
  always_ff @(posedge mclk_i) begin
    if (reset_i) img_q <= '0;
    else         img_q <= pack(acc_q, mode);
  end
  assign process_image_o = img_q;

  // ----------------------------------------------------------------
  // Bus watchdog and valve fault reaction
  // ----------------------------------------------------------------
  logic [31:0] wdog_q;
  logic        fault_q;
  logic [23:0] hold_q, valve_q;

  // Fault while no frame arrives for the monitoring time
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wdog_q  <= '0;
      fault_q <= 1'b0;
    end else if (frame_i) begin
      wdog_q  <= '0;
      fault_q <= 1'b0;
    end else if (wdog_q == WDOG_CYC - 32'd1) begin
      fault_q <= 1'b1;
    end else begin
      wdog_q  <= wdog_q + 32'd1;
    end
  end

  // Hold copy freezes at onset; per bit pick preset or held state
  wire [23:0] pick = (fact_q[23:0] & hold_q)
                   | (~fact_q[23:0] & fval_q[23:0]);
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hold_q  <= '0;
      valve_q <= '0;
    end else begin
      if (!fault_q) hold_q <= valve_q;
      valve_q <= fault_q ? pick : vout_q[23:0];
    end
  end
  assign valve_o = valve_q;

  // Fault preset reaches the valve one cycle later
  preset_out_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    fault_q && !fact_q[0] |=> valve_q[0] == $past(fval_q[0]))
    else $error("valve did not take its fault value");
  hold_out_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    fault_q && $past(fault_q) && fact_q[5] && $past(fact_q[5])
    |=> $stable(valve_q[5]))
    else $error("held valve changed during fault");

  // ----------------------------------------------------------------
  // Bus lamps
  // ----------------------------------------------------------------
  logic bo_q;
  always_ff @(posedge mclk_i) begin
    if (reset_i) bo_q <= 1'b0;
    else         bo_q <= config_ok_i & master_conn_i & ~fault_q;
  end
  assign bus_ok_lamp_o    = bo_q;
  assign bus_fault_lamp_o = ~bo_q;

  bus_lamp_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(fault_q) |=> !bus_ok_lamp_o && bus_fault_lamp_o)
    else $error("bus lamps did not show the fault");

  // ----------------------------------------------------------------
  // Latched errors and code selection
  // ----------------------------------------------------------------
  logic [3:0] err_q;
  logic [2:0] e_type, e_num;
  wire        err_any = |err_q;

  // Only reset clears these; a cured cause leaves the flag set
  always_ff @(posedge mclk_i) begin
    if (reset_i) err_q <= '0;
    else err_q <= err_q | {per_lost_i, ~per_supply_ok_i,
                           eeprom_fail_i, ~main_supply_ok_i};
  end

  // Lowest bit wins when several errors are latched
  always_comb begin
    e_type = '0;
    e_num  = '0;
    if (err_q[0]) begin
      e_type = valve_io_pkg::TYPE_MAIN;
      e_num  = valve_io_pkg::NUM_SUP;
    end else if (err_q[1]) begin
      e_type = valve_io_pkg::TYPE_MAIN;
      e_num  = valve_io_pkg::NUM_EEP;
    end else if (err_q[2]) begin
      e_type = valve_io_pkg::TYPE_PER;
      e_num  = valve_io_pkg::NUM_SUP;
    end else if (err_q[3]) begin
      e_type = valve_io_pkg::TYPE_PER;
      e_num  = valve_io_pkg::NUM_LOST;
    end
  end

  err_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    err_q[1] |=> err_q[1])
    else $error("latched error cleared without reset");
  sup_code_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    err_q[0] |-> e_type == 3'h3 && e_num == 3'h1)
    else $error("main supply code wrong");
  lost_code_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    err_q == 4'h8 |-> e_type == 3'h4 && e_num == 3'h2)
    else $error("peripheral loss code wrong");

  // ----------------------------------------------------------------
  // Flash sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {F_IDLE, F_ON, F_OFF, F_PAUSE} flash_e;
  flash_e     fst_q;
  logic [31:0] div_q;
  logic [2:0]  pul_q, pau_q;
  logic        sel_q;
  wire         tick = (div_q == TICK_CYC - 32'd1);
  wire  [2:0]  code = sel_q ? e_type : e_num;

  always_ff @(posedge mclk_i) begin
    if (reset_i || tick) div_q <= '0;
    else                 div_q <= div_q + 32'd1;
  end

  // Type burst with selector lit, then number burst with it dark
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fst_q <= F_IDLE;
      pul_q <= '0;
      pau_q <= '0;
      sel_q <= 1'b1;
    end else if (tick) begin
      case (fst_q)
        F_IDLE: begin
          if (err_any) begin
            pul_q <= code;
            fst_q <= F_ON;
          end
        end
        F_ON: begin
          pul_q <= pul_q - 3'd1;
          fst_q <= F_OFF;
        end
        F_OFF: begin
          pau_q <= '0;
          fst_q <= (pul_q == '0) ? F_PAUSE : F_ON;
        end
        F_PAUSE: begin
          pau_q <= pau_q + 3'd1;
          if (pau_q == 3'(valve_io_pkg::PAUSE_TK - 1)) begin
            sel_q <= ~sel_q;
            fst_q <= F_IDLE;
          end
        end
        default: fst_q <= F_IDLE;
      endcase
    end
  end
  assign failure_count_lamp_o    = (fst_q == F_ON);
  assign failure_selector_lamp_o = sel_q & err_any;

  burst_load_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    fst_q == F_IDLE && tick && err_any |=> pul_q == $past(code))
    else $error("burst length not taken from shown code");

  // ----------------------------------------------------------------
  // Network address
  // ----------------------------------------------------------------
  logic [39:0] nego_q;
  logic        nego_q_on, rst_seen_q, fall_q;

  // Stored settings are caught only on the first edge after reset
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rst_seen_q <= 1'b0;
      nego_q_on  <= 1'b0;
      nego_q     <= '0;
      addr_q     <= '0;
      fall_q     <= 1'b0;
    end else if (!rst_seen_q) begin
      rst_seen_q <= 1'b1;
      nego_q_on  <= nv_nego_i;
      addr_q     <= nv_addr_i;
    end else if (nego_q_on) begin
      if (addr_given_i) begin
        addr_q    <= addr_value_i;
        nego_q_on <= 1'b0;
      end else if (nego_q == NEGO_CYC - 40'd1) begin
        addr_q    <= valve_io_pkg::DEF_ADDR;
        fall_q    <= 1'b1;
        nego_q_on <= 1'b0;
      end else begin
        nego_q    <= nego_q + 40'd1;
      end
    end
  end
  assign net_addr_o       = addr_q;
  assign net_addr_store_o = netw_q;

  fallback_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    nego_q_on && !addr_given_i && nego_q == NEGO_CYC - 40'd1
    |=> addr_q == 32'hC0A80064 && fall_q)
    else $error("no default address after timeout");

  // Status word
  assign status_w = {25'h0, fall_q, err_q, bo_q, fault_q};

endmodule
`default_nettype wire

// file: bus_master_model.sv
// Purpose: Field bus master stand-in that sends frames to the block
// Assumes: Runs on the block's own clock
// Notes:   Frames stop while run_i is low, which starves the watchdog
`timescale 1ns/1ps
`default_nettype none
module bus_master_model #(
  parameter int GAP = 8
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic run_i,
  output logic      frame_o
);
  int unsigned cnt_q;
  // One frame every GAP cycles, well inside the monitoring time
  always_ff @(posedge mclk_i) begin
    if (reset_i || !run_i) begin
      cnt_q   <= 0;
      frame_o <= 1'b0;
    end else begin
      cnt_q   <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
      frame_o <= (cnt_q == GAP - 1);
    end
  end
endmodule
`default_nettype wire

// file: valve_io_fault_and_input_mapping_tb.sv
// Purpose: Self-checking bench for the valve fault and input block
// Assumes: Short counts set through the top module's parameters
// Notes:   Outputs are sampled at the falling edge to avoid races
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value at %0t: %h vs %h", $time, g, e); \
  end end
module valve_io_fault_and_input_mapping_tb;
  logic        mclk_i = 0, reset_i = 1, run = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, din = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, msup = 1, eep = 0, psup = 1, plost = 0;
  logic        cfg = 1, mcon = 1, nego = 1, given = 0;
  logic [3:0]  strb = 4'hF;
  logic [31:0] nvad = 0, gad = 0;
  logic        awready, wready, bvalid, arready, rvalid, frame;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, pimg, naddr, nstore, rd;
  logic [23:0] valve;
  logic        ok_lamp, flt_lamp, sel_lamp, cnt_lamp;
  int          n_mismatch = 0, samples_checked = 0, n;
  // ----------------------------------------------------------------
  // Clock, partner and device
  // ----------------------------------------------------------------
  always #5 mclk_i = ~mclk_i;
  bus_master_model bus_master_model_i (.mclk_i(mclk_i),
    .reset_i(reset_i), .run_i(run), .frame_o(frame));
  // Short counts keep the run brief; expectations follow them
  valve_io_fault_and_input_mapping #(.FILT_CYC(18'h8), .WDOG_CYC(32'h32),
    .TICK_CYC(32'h4), .NEGO_CYC(40'h64)) valve_io_fault_and_input_mapping_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .din_i(din), .frame_i(frame),
    .config_ok_i(cfg), .master_conn_i(mcon), .main_supply_ok_i(msup),
    .eeprom_fail_i(eep), .per_supply_ok_i(psup), .per_lost_i(plost),
    .nv_nego_i(nego), .nv_addr_i(nvad), .addr_given_i(given),
    .addr_value_i(gad), .valve_o(valve), .process_image_o(pimg),
    .net_addr_o(naddr), .net_addr_store_o(nstore), .bus_ok_lamp_o(ok_lamp),
    .bus_fault_lamp_o(flt_lamp), .failure_selector_lamp_o(sel_lamp),
    .failure_count_lamp_o(cnt_lamp));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task timeout_hit;
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  task tick(input int c);
    repeat (c) @(posedge mclk_i);
  endtask
  task look(input int c);
    tick(c);
    @(negedge mclk_i);
  endtask
  // Handshakes are judged mid-cycle; inputs only move at rising edges
  task axi_write(input logic [31:0] a, d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    int   i;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    b_t = 0;
    for (i = 0; i < 100 && !b_t; i++) begin
      @(negedge mclk_i);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge mclk_i);
      if (aw_t) awvalid <= 0;
      if (w_t) wvalid <= 0;
    end
    if (!b_t) timeout_hit();
    bready <= 0;
  endtask
  task axi_read(input logic [31:0] a, output logic [31:0] d,
                output logic [1:0] r);
    logic ar_t, r_t;
    int   i;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    r_t = 0;
    for (i = 0; i < 100 && !r_t; i++) begin
      @(negedge mclk_i);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk_i);
      if (ar_t) arvalid <= 0;
    end
    if (!r_t) timeout_hit();
    rready <= 0;
  endtask
  // Counts count-lamp pulses while the selector lamp holds one level
  task count_flash(input logic lvl, output int k);
    logic prev;
    int   i;
    k = 0;
    @(negedge mclk_i);
    prev = cnt_lamp;
    for (i = 0; i < 3000 && sel_lamp === lvl; i++) begin
      @(negedge mclk_i);
      if (cnt_lamp === 1'b1 && prev !== 1'b1) k++;
      prev = cnt_lamp;
    end
    if (sel_lamp === lvl) timeout_hit();
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(10);
    reset_i <= 0;
    run <= 1;
    look(30);
    `CHK({ok_lamp, flt_lamp}, 2'b10)
    tick(1);
    cfg <= 0;
    look(2);
    `CHK({ok_lamp, flt_lamp}, 2'b01)
    tick(1);
    {cfg, mcon} <= 2'b10;
    look(2);
    `CHK({ok_lamp, flt_lamp}, 2'b01)
    tick(1);
    mcon <= 1;
    axi_read(32'(valve_io_pkg::ADDR_CTRL), rd, rs);
    `CHK(rd, valve_io_pkg::CTRL_RST)
    axi_read(32'h20, rd, rs);
    `CHK(rs, valve_io_pkg::RESP_ERR)
    look(120);
    `CHK(naddr, valve_io_pkg::DEF_ADDR)
    axi_write(32'(valve_io_pkg::ADDR_NETW), 32'h0A000001, rs);
    look(2);
    `CHK({nstore, naddr}, {32'h0A000001, valve_io_pkg::DEF_ADDR})
    axi_write(32'(valve_io_pkg::ADDR_STAT), 32'h0, rs);
    `CHK(rs, valve_io_pkg::RESP_ERR)
    din <= 32'h80000006;
    look(40);
    `CHK(pimg, 32'h80000006)
    axi_write(32'(valve_io_pkg::ADDR_CTRL), 32'h3, rs);
    look(4);
    `CHK(pimg, 32'h80000102)
    axi_write(32'(valve_io_pkg::ADDR_CTRL), 32'h5, rs);
    look(4);
    `CHK(pimg, 32'h00000002)
    // Filter stays enabled, as configurators are advised to do
    axi_write(32'(valve_io_pkg::ADDR_CTRL), 32'h1, rs);
    din <= 32'h0;
    tick(5);
    din <= 32'h80000006;
    look(3);
    `CHK(pimg, 32'h80000006)
    look(37);
    `CHK(pimg, 32'h80000006)
    axi_write(32'(valve_io_pkg::ADDR_FACT), 32'hF0, rs);
    axi_write(32'(valve_io_pkg::ADDR_FVAL), 32'h55, rs);
    axi_write(32'(valve_io_pkg::ADDR_VOUT), 32'hAA, rs);
    look(3);
    `CHK(valve, 24'h0000AA)
    tick(1);
    run <= 0;
    look(70);
    `CHK({ok_lamp, flt_lamp}, 2'b01)
    `CHK(valve, 24'h0000A5)
    // A new command during the fault must not reach the valves
    tick(1);
    strb <= 4'h2;
    axi_write(32'(valve_io_pkg::ADDR_VOUT), 32'h3C0F, rs);
    look(2);
    `CHK(valve, 24'h0000A5)
    tick(1);
    strb <= 4'hF;
    run <= 1;
    msup <= 0;
    eep <= 1;
    psup <= 0;
    plost <= 1;
    tick(1);
    {msup, eep, psup, plost} <= 4'hA;
    look(20);
    `CHK(ok_lamp, 1'b1)
    `CHK(valve, 24'h003CAA)
    axi_read(32'(valve_io_pkg::ADDR_STAT), rd, rs);
    `CHK(rd[6:2], 5'h1F)
    count_flash(1'b1, n);
    count_flash(1'b0, n);
    `CHK(n, 1)
    count_flash(1'b1, n);
    `CHK(n, 3)
    // Power cycle: stored address adopted, latched errors gone
    tick(1);
    reset_i <= 1;
    nvad <= 32'h0A000002;
    tick(10);
    reset_i <= 0;
    look(3);
    `CHK(naddr, 32'h0A000002)
    tick(1);
    {given, gad} <= {1'b1, 32'h0A0000FE};
    plost <= 1;
    tick(1);
    {given, plost} <= 2'b00;
    look(120);
    `CHK(naddr, 32'h0A0000FE)
    axi_read(32'(valve_io_pkg::ADDR_STAT), rd, rs);
    `CHK(rd[6:2], 5'h08)
    report_and_stop();
  end
endmodule
`default_nettype wire
